/* File: hdl/agoc_regs.vh */
// Register map, field positions and constants of the gain and offset corrector
`ifndef AGOC_REGS_VH
`define AGOC_REGS_VH

// Coefficient register indexes (byte address is four times the index)
`define AGOC_IDX_CH11_ODD   8'h29
`define AGOC_IDX_CH11_EVEN  8'h2a
`define AGOC_IDX_CH12_ODD   8'h2b
`define AGOC_IDX_CH12_EVEN  8'h2c
// Configuration register 3 holds the global enables
`define AGOC_IDX_CFG3       8'h03

// Field positions
`define AGOC_GAIN_MSB       15
`define AGOC_GAIN_LSB       11
`define AGOC_OFFS_MSB       9
`define AGOC_OFFS_LSB       0
`define AGOC_GAIN_EN_BIT    12
`define AGOC_OFFS_EN_BIT    8

// Reset values and writable masks
`define AGOC_COEF_RESET     16'h0000
`define AGOC_COEF_MASK      16'hfbff
`define AGOC_CFG3_MASK      16'h1100

// Sample width (14-bit LSB weight) and gain table fraction bits
`define AGOC_SAMPLE_W       14
`define AGOC_GAIN_FRAC      14

`endif

/* File: hdl/agoc_top.v */
// Gain and offset correction for channels 11 and 12 with APB register access
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
`include "agoc_regs.vh"

// Behaviour
// RULE1 - gain is 5-bit code times 0.2 dB
// RULE2 - subtract 10-bit offset when offset enabled
// RULE3 - offset is two's complement, 14-bit LSB
// RULE4 - separate odd and even coefficient sets
// RULE5 - gain applied only when gain enable set
// RULE6 - offset applied only when offset enable set
// RULE7 - disabled stage passes through; coefficients reset zero
module agoc_top
(
	// Clock and reset
	input  wire        clk,
	input  wire        reset,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Sample input: channel 0 is 11, 1 is 12; odd flags the odd slice
	input  wire        sample_valid,
	input  wire        sample_channel,
	input  wire        sample_odd,
	input  wire [13:0] sample_in,
	// Corrected sample output
	output reg         corr_valid,
	output reg         corr_channel,
	output reg         corr_odd,
	output reg  [13:0] corr_out
);

	// ****************************************
	// Storage
	// ****************************************
	reg  [15:0] coef_q [0:3];   // ch11 odd, ch11 even, ch12 odd, ch12 even
	reg  [15:0] cfg3_q;
	reg  [13:0] stage_q;
	reg         stage_valid_q;
	reg         stage_channel_q;
	reg         stage_odd_q;
	reg  [4:0]  stage_gain_q;
	integer     i;

	// ****************************************
	// Functions
	// ****************************************

	// Register index of a byte address, 8'hff when misaligned or at byte address 400h or above
	function [7:0] agoc_index;
		input [11:0] addr;
		begin
			if ((addr[1:0] != 2'b00) || (addr[11:10] != 2'b00))
				agoc_index = 8'hff;
			else
				agoc_index = addr[9:2];
		end
	endfunction

	// Linear factor 10^(N/100), i.e. N steps of 0.2 dB, in Q4.14 for N = 0..31
	// Entries are rounded to nearest, so no step drifts by more than half an LSB
	function [17:0] agoc_gain_lin;
		input [4:0] code;
		begin
			case (code)
				5'd0:  agoc_gain_lin = 18'h0_4000;
				5'd1:  agoc_gain_lin = 18'h0_417E;
				5'd2:  agoc_gain_lin = 18'h0_4304;
				5'd3:  agoc_gain_lin = 18'h0_4494;
				5'd4:  agoc_gain_lin = 18'h0_462D;
				5'd5:  agoc_gain_lin = 18'h0_47CF;
				5'd6:  agoc_gain_lin = 18'h0_497B;
				5'd7:  agoc_gain_lin = 18'h0_4B32;
				5'd8:  agoc_gain_lin = 18'h0_4CF2;
				5'd9:  agoc_gain_lin = 18'h0_4EBD;
				5'd10: agoc_gain_lin = 18'h0_5092;
				5'd11: agoc_gain_lin = 18'h0_5273;
				5'd12: agoc_gain_lin = 18'h0_545E;
				5'd13: agoc_gain_lin = 18'h0_5655;
				5'd14: agoc_gain_lin = 18'h0_5858;
				5'd15: agoc_gain_lin = 18'h0_5A67;
				5'd16: agoc_gain_lin = 18'h0_5C82;
				5'd17: agoc_gain_lin = 18'h0_5EAA;
				5'd18: agoc_gain_lin = 18'h0_60DE;
				5'd19: agoc_gain_lin = 18'h0_6320;
				5'd20: agoc_gain_lin = 18'h0_656F;
				5'd21: agoc_gain_lin = 18'h0_67CC;
				5'd22: agoc_gain_lin = 18'h0_6A37;
				5'd23: agoc_gain_lin = 18'h0_6CB0;
				5'd24: agoc_gain_lin = 18'h0_6F38;
				5'd25: agoc_gain_lin = 18'h0_71CF;
				5'd26: agoc_gain_lin = 18'h0_7476;
				5'd27: agoc_gain_lin = 18'h0_772C;
				5'd28: agoc_gain_lin = 18'h0_79F3;
				5'd29: agoc_gain_lin = 18'h0_7CCA;
				5'd30: agoc_gain_lin = 18'h0_7FB2;
				default: agoc_gain_lin = 18'h0_82AC;
			endcase
		end
	endfunction

	// Clamp a signed value to the unsigned 14-bit sample range
	function [13:0] agoc_clamp;
		input signed [35:0] v;
		begin
			if (v < 36'sd0)
				agoc_clamp = 14'h0000;
			else if (v > 36'sd16383)
				agoc_clamp = 14'h3fff;
			else
				agoc_clamp = v[13:0];
		end
	endfunction

	// ****************************************
	// APB decode
	// ****************************************
	wire [7:0]  acc_idx   = agoc_index(paddr);
	wire        acc_setup = psel & ~penable;
	// Addresses outside the four coefficient words and cfg3 answer with an error
	wire        acc_hit   = (acc_idx >= `AGOC_IDX_CH11_ODD) && (acc_idx <= `AGOC_IDX_CH12_EVEN);
	wire        acc_cfg   = (acc_idx == `AGOC_IDX_CFG3);
	wire [1:0]  acc_slot  = acc_idx[1:0] - 2'b01;  // 29h..2Ch map to 0..3

	// Register writes and read answers; no wait state, answer in access phase
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			for (i = 0; i < 4; i = i + 1)
				coef_q[i] <= `AGOC_COEF_RESET;   // see RULE7
			cfg3_q  <= 16'h0000;
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= acc_setup;
			pslverr <= acc_setup & ~(acc_hit | acc_cfg);
			// Reads load prdata at the setup edge so it stands during the access phase
			if (acc_setup & ~pwrite)
			begin
				if (acc_hit)
					prdata <= {16'h0000, coef_q[acc_slot]};
				else if (acc_cfg)
					prdata <= {16'h0000, cfg3_q};
				else
					prdata <= 32'h0000_0000;
			end
			// Writes take effect at the completing access edge
			if (psel & penable & pready & pwrite)
			begin
				if (acc_hit)
					coef_q[acc_slot] <= pwdata[15:0] & `AGOC_COEF_MASK;
				else if (acc_cfg)
					cfg3_q <= pwdata[15:0] & `AGOC_CFG3_MASK;
			end
		end
	end

	// ****************************************
	// Datapath
	// ****************************************
	wire        gain_correction_enable   = cfg3_q[`AGOC_GAIN_EN_BIT];
	wire        offset_correction_enable = cfg3_q[`AGOC_OFFS_EN_BIT];
	// Coefficient slot follows the channel and slice tags of the incoming sample
	wire [15:0] sel_coef = coef_q[{sample_channel, ~sample_odd}];  // see RULE4
	wire signed [9:0]  offset_value = sel_coef[`AGOC_OFFS_MSB:`AGOC_OFFS_LSB];  // see RULE3
	// Offset is sign-extended so a negative coefficient raises the sample
	wire signed [15:0] offs_sum = $signed({2'b00, sample_in}) - {{6{offset_value[9]}}, offset_value};
	wire [13:0] offs_res = offset_correction_enable ?
		agoc_clamp({{20{offs_sum[15]}}, offs_sum}) : sample_in;  // see RULE2, RULE6, RULE7
	wire [17:0] gain_lin = agoc_gain_lin(stage_gain_q);  // see RULE1
	// Full 32-bit product; dropping the 14 fraction bits truncates the result
	wire [31:0] gain_prod = stage_q * gain_lin;
	wire [17:0] gain_shift = gain_prod[31:`AGOC_GAIN_FRAC];

	// Stage 1: offset; stage 2: gain
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			stage_q         <= 14'h0000;
			stage_valid_q   <= 1'b0;
			stage_channel_q <= 1'b0;
			stage_odd_q     <= 1'b0;
			stage_gain_q    <= 5'h00;
			corr_valid      <= 1'b0;
			corr_channel    <= 1'b0;
			corr_odd        <= 1'b0;
			corr_out        <= 14'h0000;
		end
		else
		begin
			stage_valid_q   <= sample_valid;
			stage_channel_q <= sample_channel;
			stage_odd_q     <= sample_odd;
			if (sample_valid)
			begin
				stage_q      <= offs_res;
				stage_gain_q <= sel_coef[`AGOC_GAIN_MSB:`AGOC_GAIN_LSB];
			end
			corr_valid   <= stage_valid_q;
			corr_channel <= stage_channel_q;
			corr_odd     <= stage_odd_q;
			if (stage_valid_q)
			begin
				if (gain_correction_enable)  // see RULE5
					corr_out <= agoc_clamp({18'h0_0000, gain_shift});  // see RULE1
				else
					corr_out <= stage_q;  // see RULE7
			end
		end
	end

endmodule

/* File: tb/agoc_checker.sv */
// Checker for sample pipeline timing and register handshake
`timescale 1ns/100ps
module agoc_checker
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// Sample path
	input wire logic sample_valid,
	input wire logic sample_channel,
	input wire logic sample_odd,
	input wire logic corr_valid,
	input wire logic corr_channel,
	input wire logic corr_odd
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	property p_lat; sample_valid |-> ##2 corr_valid; endproperty
	a_lat: assert property (p_lat) else $error("result missing");
	property p_tag;
		sample_valid |-> ##2 (corr_odd == $past(sample_odd, 2)
			&& corr_channel == $past(sample_channel, 2));
	endproperty
	a_tag: assert property (p_tag) else $error("slice tag wrong");
	property p_idle; !sample_valid |-> ##2 !corr_valid; endproperty
	a_idle: assert property (p_idle) else $error("spurious result");
	property p_rdy; psel && !penable |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("ready too long");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("error without ready");
endmodule
bind agoc_top agoc_checker u_chk (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .sample_valid(sample_valid), .sample_channel(sample_channel),
	.sample_odd(sample_odd), .corr_valid(corr_valid), .corr_channel(corr_channel),
	.corr_odd(corr_odd));

/* File: tb/agoc_tb.sv */
// Self-checking bench for the gain and offset corrector
`timescale 1ns/100ps
`include "agoc_regs.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
	$display("ERROR %0t: got %h expected %h", $time, a, b); end end
module adc_gain_offset_correction_tb_top;
	logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, err, sv = 0, sch = 0, sodd = 0, cv, cch, codd;
	logic [13:0] sin = 0, cout;
	logic [7:0] idx [4] = '{`AGOC_IDX_CH11_ODD, `AGOC_IDX_CH11_EVEN, `AGOC_IDX_CH12_ODD,
		`AGOC_IDX_CH12_EVEN};
	logic [9:0] offs [4] = '{10'h3fb, 10'h003, 10'h200, 10'h1ff};
	int n_errors = 0, compares = 0;
	agoc_top dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sample_valid(sv), .sample_channel(sch), .sample_odd(sodd), .sample_in(sin),
		.corr_valid(cv), .corr_channel(cch), .corr_odd(codd), .corr_out(cout));
	always #10 clk = ~clk;
	// APB transfer: setup, access, wait for ready
	task bus(input logic w, input logic [7:0] i, input logic [15:0] d);
		@(posedge clk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= {2'b00, i, 2'b00}; pwdata <= {16'h0000, d};
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (!pready);
		rd = prdata; err = pslverr;
		psel <= 0; penable <= 0;
	endtask
	// One sample in, result checked two edges later
	task smp(input int i, input logic [13:0] x, input logic [13:0] e);
		@(posedge clk);
		sv <= 1; sch <= i[1]; sodd <= ~i[0]; sin <= x;
		@(posedge clk);
		sv <= 0;
		@(posedge clk);
		#1 `CHK({cv, cch, codd, cout}, {1'b1, i[1], ~i[0], e})
	endtask
	task t_reset;
		for (int i = 0; i < 4; i++) begin bus(0, idx[i], 0); `CHK(rd, 32'h0000_0000) end
		bus(0, 8'h30, 0);
		`CHK(err, 1'b1)
	endtask
	task t_pass;
		bus(1, `AGOC_IDX_CFG3, 16'h0000);
		for (int i = 0; i < 4; i++)
		begin
			bus(1, idx[i], 16'hf5ff);
			bus(0, idx[i], 0);
			`CHK(rd, 32'h0000_f1ff)
			smp(i, 14'h0d05, 14'h0d05);
		end
	endtask
	task t_off;
		bus(1, `AGOC_IDX_CFG3, 16'h0100);
		for (int i = 0; i < 4; i++)
		begin
			bus(1, idx[i], {6'h00, offs[i]});
			smp(i, 14'd2000, 14'(2000 - int'($signed(offs[i]))));
		end
	endtask
	task t_gain;
		bus(1, `AGOC_IDX_CFG3, 16'hffff);
		bus(0, `AGOC_IDX_CFG3, 0);
		`CHK(rd, 32'h0000_1100)
		bus(1, `AGOC_IDX_CFG3, 16'h1000);
		bus(1, idx[3], 16'hf003);
		smp(3, 14'd1000, 14'd1995);
		smp(2, 14'd1000, 14'd1000);
	endtask
	// Reset in mid-run must clear coefficients and enables again
	task t_rerun;
		@(posedge clk);
		reset <= 1;
		repeat (3) @(posedge clk);
		reset <= 0;
		bus(0, idx[3], 0);
		`CHK(rd, 32'h0000_0000)
		bus(0, `AGOC_IDX_CFG3, 0);
		`CHK(rd, 32'h0000_0000)
	endtask
	task conclude;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		reset <= 0;
		t_reset; t_pass; t_off; t_gain; t_rerun;
		conclude;
	end
	initial
	begin
		#100000;
		n_errors++;
		conclude;
	end
endmodule
